// ===== logic/sbs_defines.svh
// Purpose: Constants for the synchronous burst SRAM cycle control.
// Assumes: Included by the package, the core and the bench modules.
// Notes:   Widths, lane layout, burst and wake-up figures.
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

`define SBS_ADDR_W     15
`define SBS_LANES      4
`define SBS_LANE_W     9
`define SBS_DATA_W     36
`define SBS_BURST_W    2
`define SBS_FIFO_DEPTH 8
`define SBS_WAKE_CYC   2'h2
`define SBS_CNT_ONE    2'h1
`define SBS_CNT_ZERO   2'h0
`define SBS_ALL_LANES  4'hF
`define SBS_NO_LANES   4'h0

`endif

// ===== logic/sbs_pkg.sv
// Purpose: Types and shared decode functions for the burst SRAM.
// Assumes: sbs_defines.svh supplies all widths.
// Notes:   Functions are used by the core and its assertions.
`include "sbs_defines.svh"

package sbs_pkg;

  typedef enum logic [2:0] {
    SBS_RUN   = 3'b001,
    SBS_SLEEP = 3'b010,
    SBS_WAKE  = 3'b100
  } sbs_mode_t;

  // Synchronous inputs sampled on each rising edge
  typedef struct packed {
    logic                     chip_select_first_n;
    logic                     chip_select_second;
    logic                     chip_select_third_n;
    logic                     proc_addr_strobe_n;
    logic                     ctrl_addr_strobe_n;
    logic                     burst_advance_n;
    logic                     global_write_n;
    logic                     byte_group_write_n;
    logic [`SBS_LANES-1:0]    lane_write_n;
    logic [`SBS_ADDR_W-1:0]   addr;
  } sbs_cmd_t;

  // One write waiting to reach the array
  typedef struct packed {
    logic [`SBS_ADDR_W-1:0]   addr;
    logic [`SBS_DATA_W-1:0]   data;
    logic [`SBS_LANES-1:0]    lanes;
  } sbs_wentry_t;

  typedef struct packed {
    sbs_mode_t                mode;
    logic [1:0]               wake_cnt;
    logic [`SBS_ADDR_W-1:0]   base_addr;
    logic [`SBS_BURST_W-1:0]  cnt;
    logic                     rd_pend;
    logic [`SBS_ADDR_W-1:0]   rd_addr;
    logic [`SBS_DATA_W-1:0]   dout;
    logic [`SBS_LANES-1:0]    drive;
  } sbs_state_t;

  // Byte lanes written; all-zero means a read
  function automatic logic [`SBS_LANES-1:0] sbs_lane_decode(
    input logic                  gw_n,
    input logic                  bw_n,
    input logic [`SBS_LANES-1:0] we_n
  );
    if (!gw_n) begin
      return `SBS_ALL_LANES;
    end else if (!bw_n) begin
      return ~we_n;
    end
    return `SBS_NO_LANES;
  endfunction

  // Burst address from start address and beat count
  function automatic logic [`SBS_ADDR_W-1:0] sbs_burst_addr(
    input logic [`SBS_ADDR_W-1:0]  base,
    input logic [`SBS_BURST_W-1:0] cnt,
    input logic                    interleaved
  );
    logic [`SBS_BURST_W-1:0] low;
    low = interleaved ? (base[`SBS_BURST_W-1:0] ^ cnt)
                      : (base[`SBS_BURST_W-1:0] + cnt);
    return {base[`SBS_ADDR_W-1:`SBS_BURST_W], low};
  endfunction

endpackage

// ===== logic/sbs_fifo.sv
// Purpose: Small valid/ready FIFO for writes on their way to the array.
// Assumes: DEPTH is a power of two, at least two.
// Notes:   Full and empty are exact; a full FIFO drops in_ready_o.
`timescale 1ns/1ps

module sbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin
      $error("sbs_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
  } sbs_fifo_state_t;

  sbs_fifo_state_t  st_ff;
  sbs_fifo_state_t  nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = (st_ff.count != DEPTH[PTR_W:0]);
  assign out_valid_o = (st_ff.count != '0);
  assign out_data_o  = mem_ff[st_ff.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[st_ff.wr_ptr] <= in_data_i;
    end
  end

endmodule

// ===== logic/sbs_core.sv
// Purpose: Cycle control and array of a pipelined burst SRAM.
// Assumes: All inputs but sleep and output enable are synchronous.
// Notes:   Writes pass a FIFO before the array; reads take two edges.
//
// How it works
// - Processor strobe with chip selected loads address, starts a read.
// - Controller strobe alone loads address; write if lanes set, else read.
// - No strobe, advance low, no write: step burst address and read.
// - No strobe, advance low, write: step burst address and write.
// - No strobe, advance high, no write: repeat read at same address.
// - No strobe, advance high, write: write again at same address.
// - Write term is active exactly when any byte lane is selected.
// - Global write takes all lanes; else byte-group enables lane enables.
// - Sleep high floats the data bus regardless of output enable.
// - Bus drive is gated at once by sleep and output enable.
// - Deselect and write cycles leave the bus undriven.
// - Read right after a write shows the newly written data.
// - After an all-lane write, all lanes show the written data.
// - After a one-lane write, only that lane shows forwarded data.
// - Four-beat burst, linear or interleaved, wraps to the start.
// - Advance and lane enables ignored on a processor strobe edge.
// - Two wake-up cycles after sleep ends; state is kept.
// - Each lane enable covers eight data bits and one parity bit.
`timescale 1ns/1ps
`include "sbs_defines.svh"

module sbs_core
  import sbs_pkg::*;
#(
  parameter int FIFO_DEPTH = `SBS_FIFO_DEPTH
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   srst_i,
  input  wire sbs_cmd_t               cmd_i,
  input  wire logic                   burst_order_select_i,
  input  wire logic                   sleep_request_i,
  input  wire logic                   output_enable_n_i,
  input  wire logic [`SBS_DATA_W-1:0] dq_i,
  output logic [`SBS_DATA_W-1:0]      dq_o,
  output logic [`SBS_LANES-1:0]       dq_oe_n_o
);

  localparam int WENT_W = $bits(sbs_wentry_t);

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("sbs_core: FIFO_DEPTH must be at least two");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle decode

  sbs_state_t              st_ff;
  sbs_state_t              nxt_st;
  logic [`SBS_DATA_W-1:0]  array_ff [1 << `SBS_ADDR_W];

  logic                    awake;
  logic                    cs_ok;
  logic                    desel;
  logic                    proc_addr_strobe_n_start;
  logic                    ctrl_addr_strobe_n_start;
  logic                    cont;
  logic [`SBS_LANES-1:0]   lanes;
  logic                    write_cyc;
  logic                    wr_ready;
  logic                    wr_push;
  logic [`SBS_ADDR_W-1:0]  acc_addr;
  logic [`SBS_BURST_W-1:0] acc_cnt;
  logic                    access;
  sbs_wentry_t             wr_in;
  sbs_wentry_t             wr_out;
  logic                    wr_out_valid;
  logic                    drain;
  logic [`SBS_DATA_W-1:0]  rd_word;

  assign awake = (st_ff.mode == SBS_RUN) && !sleep_request_i;

  assign cs_ok = !cmd_i.chip_select_first_n && cmd_i.chip_select_second
                 && !cmd_i.chip_select_third_n;
  assign desel = (cmd_i.chip_select_first_n && !cmd_i.ctrl_addr_strobe_n)
                 || ((!cmd_i.proc_addr_strobe_n
                      || !cmd_i.ctrl_addr_strobe_n)
                     && !cmd_i.chip_select_first_n
                     && (!cmd_i.chip_select_second
                         || cmd_i.chip_select_third_n));
  assign proc_addr_strobe_n_start = !cmd_i.proc_addr_strobe_n && cs_ok;
  assign ctrl_addr_strobe_n_start = cmd_i.proc_addr_strobe_n
                      && !cmd_i.ctrl_addr_strobe_n && cs_ok;
  assign cont = cmd_i.ctrl_addr_strobe_n
                && (cmd_i.proc_addr_strobe_n
                    || cmd_i.chip_select_first_n);

  // Lane enables ignored on the processor strobe edge
  assign lanes = proc_addr_strobe_n_start ? `SBS_NO_LANES
               : sbs_lane_decode(cmd_i.global_write_n,
                                 cmd_i.byte_group_write_n,
                                 cmd_i.lane_write_n);
  assign write_cyc = (lanes != `SBS_NO_LANES);

  always_comb begin
    acc_cnt  = st_ff.cnt;
    acc_addr = sbs_burst_addr(st_ff.base_addr, st_ff.cnt,
                              burst_order_select_i);
    access   = 1'b0;
    if (proc_addr_strobe_n_start || ctrl_addr_strobe_n_start) begin
      acc_cnt  = `SBS_CNT_ZERO;
      acc_addr = cmd_i.addr;
      access   = 1'b1;
    end else if (cont) begin
      access = 1'b1;
      if (!cmd_i.burst_advance_n) begin
        acc_cnt  = st_ff.cnt + `SBS_CNT_ONE;
        acc_addr = sbs_burst_addr(st_ff.base_addr, acc_cnt,
                                  burst_order_select_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write path through the FIFO

  assign wr_in.addr  = acc_addr;
  assign wr_in.data  = dq_i;
  assign wr_in.lanes = lanes;
  assign wr_push     = awake && access && write_cyc;
  // Array is powered down while asleep, so the drain stalls
  assign drain       = wr_out_valid && (st_ff.mode == SBS_RUN);

  sbs_fifo #(
    .WIDTH (WENT_W),
    .DEPTH (FIFO_DEPTH)
  ) i_sbs_fifo (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .in_valid_i  (wr_push),
    .in_ready_o  (wr_ready),
    .in_data_i   (wr_in),
    .out_valid_o (wr_out_valid),
    .out_ready_i (drain),
    .out_data_o  (wr_out)
  );

  always_ff @(posedge clk_sys_i) begin
    for (int l = 0; l < `SBS_LANES; l++) begin
      if (drain && wr_out.lanes[l]) begin
        array_ff[wr_out.addr][l*`SBS_LANE_W +: `SBS_LANE_W] <=
          wr_out.data[l*`SBS_LANE_W +: `SBS_LANE_W];
      end
    end
  end

  assign rd_word = array_ff[st_ff.rd_addr];

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rd_pend = 1'b0;
    nxt_st.drive   = `SBS_NO_LANES;
    case (st_ff.mode)
      SBS_RUN: begin
        if (sleep_request_i) begin
          nxt_st.mode = SBS_SLEEP;
        end
      end
      SBS_SLEEP: begin
        if (!sleep_request_i) begin
          nxt_st.mode     = SBS_WAKE;
          nxt_st.wake_cnt = `SBS_WAKE_CYC - 2'h1;
        end
      end
      SBS_WAKE: begin
        if (sleep_request_i) begin
          nxt_st.mode = SBS_SLEEP;
        end else if (st_ff.wake_cnt == `SBS_CNT_ZERO) begin
          nxt_st.mode = SBS_RUN;
        end else begin
          nxt_st.wake_cnt = st_ff.wake_cnt - 2'h1;
        end
      end
      default: begin
        nxt_st.mode = SBS_RUN;
      end
    endcase
    if (st_ff.rd_pend) begin
      nxt_st.dout  = rd_word;
      nxt_st.drive = `SBS_ALL_LANES;
    end
    if (awake && access) begin
      if (proc_addr_strobe_n_start || ctrl_addr_strobe_n_start) begin
        nxt_st.base_addr = cmd_i.addr;
      end
      nxt_st.cnt = acc_cnt;
      if (write_cyc) begin
        // Written lanes are forwarded in the next cycle
        if (wr_ready) begin
          for (int l = 0; l < `SBS_LANES; l++) begin
            if (lanes[l]) begin
              nxt_st.dout[l*`SBS_LANE_W +: `SBS_LANE_W] =
                dq_i[l*`SBS_LANE_W +: `SBS_LANE_W];
            end
          end
          nxt_st.drive = lanes;
        end
      end else begin
        nxt_st.rd_pend = 1'b1;
        nxt_st.rd_addr = acc_addr;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff      <= '0;
      st_ff.mode <= SBS_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dq_o = st_ff.dout;
  // Host floats the bus with output enable before writing; a write
  // presented now floats it too, so forwarding never fights write data
  assign dq_oe_n_o = ~(st_ff.drive
                       & {`SBS_LANES{!output_enable_n_i
                                     && !sleep_request_i
                                     && !wr_push}});

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_rd_start;
    @(posedge clk_sys_i) disable iff (srst_i)
    awake && proc_addr_strobe_n_start |=> st_ff.rd_pend && st_ff.rd_addr == $past(cmd_i.addr)
      ##1 st_ff.drive == `SBS_ALL_LANES;
  endproperty
  a_rd_start: assert property (p_rd_start)
    else $error("processor strobe read did not start");

  property p_ctrl_addr_strobe_n_wr;
    @(posedge clk_sys_i) disable iff (srst_i)
    awake && ctrl_addr_strobe_n_start && wr_ready && !cmd_i.global_write_n
      |=> st_ff.drive == `SBS_ALL_LANES && st_ff.dout == $past(dq_i)
          && !st_ff.rd_pend;
  endproperty
  a_ctrl_addr_strobe_n_wr: assert property (p_ctrl_addr_strobe_n_wr)
    else $error("controller strobe write not taken");

  property p_cont_step;
    @(posedge clk_sys_i) disable iff (srst_i)
    awake && cont && !cmd_i.burst_advance_n && !write_cyc
      |=> st_ff.cnt == $past(st_ff.cnt) + `SBS_CNT_ONE && st_ff.rd_pend;
  endproperty
  a_cont_step: assert property (p_cont_step)
    else $error("burst did not advance");

  property p_suspend;
    @(posedge clk_sys_i) disable iff (srst_i)
    awake && cont && cmd_i.burst_advance_n
      |=> st_ff.cnt == $past(st_ff.cnt)
          && st_ff.base_addr == $past(st_ff.base_addr);
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("suspended burst moved its address");

  property p_desel;
    @(posedge clk_sys_i) disable iff (srst_i)
    awake && desel && !st_ff.rd_pend |=> st_ff.drive == `SBS_NO_LANES;
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselected cycle drove the bus");

  property p_sleep_float;
    @(posedge clk_sys_i) disable iff (srst_i)
    sleep_request_i |-> dq_oe_n_o == `SBS_ALL_LANES;
  endproperty
  a_sleep_float: assert property (p_sleep_float)
    else $error("bus driven during sleep");

  property p_wake;
    @(posedge clk_sys_i) disable iff (srst_i)
    st_ff.mode == SBS_SLEEP && !sleep_request_i ##1 !sleep_request_i [*2]
      |=> st_ff.mode == SBS_RUN && $past(st_ff.mode) == SBS_WAKE
          && $past(st_ff.mode, 2) == SBS_WAKE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake-up time not two cycles");

  property p_lane_fwd;
    @(posedge clk_sys_i) disable iff (srst_i)
    wr_push && wr_ready && cmd_i.global_write_n
      |=> st_ff.drive == ~$past(cmd_i.lane_write_n);
  endproperty
  a_lane_fwd: assert property (p_lane_fwd)
    else $error("forwarded lanes differ from written lanes");

  property p_oe_gate;
    @(posedge clk_sys_i) disable iff (srst_i)
    output_enable_n_i |-> dq_oe_n_o == `SBS_ALL_LANES;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("bus driven with output enable high");

  property p_wr_float;
    @(posedge clk_sys_i) disable iff (srst_i)
    wr_push |-> dq_oe_n_o == `SBS_ALL_LANES;
  endproperty
  a_wr_float: assert property (p_wr_float)
    else $error("bus driven during a write cycle");

endmodule

// ===== tb/sbs_host_bus.sv
// Purpose: Host side of the shared data bus of the burst SRAM.
// Assumes: One host; lanes of nine bits.
// Notes:   A lane that nobody drives shows the inverse of its last level.
`timescale 1ns/1ps
`include "sbs_defines.svh"

module sbs_host_bus
  import sbs_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic [`SBS_DATA_W-1:0] dq_o_i,
  input  wire logic [`SBS_LANES-1:0]  dq_oe_n_i,
  input  wire logic                   host_drv_i,
  input  wire logic [`SBS_DATA_W-1:0] host_dq_i,
  output logic [`SBS_DATA_W-1:0]      bus_o,
  output logic                        clash_o
);
  localparam int lw = `SBS_LANE_W;
  logic [`SBS_DATA_W-1:0] last_ff = '0;

  // Device lane wins, then host; a released lane drifts every cycle
  always_comb begin
    for (int l = 0; l < `SBS_LANES; l++) begin
      if (!dq_oe_n_i[l]) begin
        bus_o[l*lw +: lw] = dq_o_i[l*lw +: lw];
      end else if (host_drv_i) begin
        bus_o[l*lw +: lw] = host_dq_i[l*lw +: lw];
      end else begin
        bus_o[l*lw +: lw] = ~last_ff[l*lw +: lw];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    last_ff <= bus_o;
  end

  // Host drives only with output enable raised, so the device must float
  assign clash_o = host_drv_i && (dq_oe_n_i != `SBS_ALL_LANES);

endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the burst SRAM cycle control.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes:   Each scenario fills a cycle table that run_tab plays and checks.
`timescale 1ns/1ps
`include "sbs_defines.svh"

module tb
  import sbs_pkg::*;
;
  localparam logic [14:0] a0 = 15'h0010;
  localparam logic [14:0] a1 = 15'h0011;
  logic                   clk_sys_i;
  logic                   srst_i;
  logic                   bo_sel;
  logic                   slp;
  logic                   oe_n;
  logic                   h_drv;
  logic                   clash;
  sbs_cmd_t               cmd;
  logic [`SBS_DATA_W-1:0] h_dq;
  logic [`SBS_DATA_W-1:0] bus;
  logic [`SBS_DATA_W-1:0] dq_o;
  logic [`SBS_LANES-1:0]  dq_oe_n;
  int                     bad_count;
  int                     check_count;
  sbs_cmd_t               t_cmd [12];
  logic [`SBS_DATA_W-1:0] t_dq  [12];
  logic [`SBS_DATA_W-1:0] t_ed  [12];
  logic [`SBS_LANES-1:0]  t_eo  [12];
  logic                   t_w   [12];
  logic                   t_sl  [12];

  sbs_core #(.FIFO_DEPTH(`SBS_FIFO_DEPTH)) i_sbs_core (
    .clk_sys_i            (clk_sys_i),
    .srst_i               (srst_i),
    .cmd_i                (cmd),
    .burst_order_select_i (bo_sel),
    .sleep_request_i      (slp),
    .output_enable_n_i    (oe_n),
    .dq_i                 (bus),
    .dq_o                 (dq_o),
    .dq_oe_n_o            (dq_oe_n)
  );

  sbs_host_bus i_sbs_host_bus (
    .clk_sys_i  (clk_sys_i),
    .dq_o_i     (dq_o),
    .dq_oe_n_i  (dq_oe_n),
    .host_drv_i (h_drv),
    .host_dq_i  (h_dq),
    .bus_o      (bus),
    .clash_o    (clash)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [`SBS_DATA_W-1:0] pt(logic [8:0] k);
    return {4{k}};
  endfunction

  function automatic logic [`SBS_DATA_W-1:0] lm(logic [`SBS_LANES-1:0] eo);
    for (int l = 0; l < `SBS_LANES; l++) begin
      lm[l*`SBS_LANE_W +: `SBS_LANE_W] = {`SBS_LANE_W{~eo[l]}};
    end
  endfunction

  task automatic chk(logic [`SBS_DATA_W-1:0] g, logic [`SBS_DATA_W-1:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: expected %h, got %h", $time, e, g);
    end
  endtask

  // Host writes only with output enable high
  task automatic row(int i, logic [7:0] c, logic [3:0] we, logic [14:0] a,
                     logic [35:0] d, logic w, logic [3:0] eo, logic [35:0] ed);
    t_cmd[i] = sbs_cmd_t'({c, we, a});
    t_dq[i]  = d;
    t_w[i]   = w;
    t_eo[i]  = eo;
    t_ed[i]  = ed;
    t_sl[i]  = 1'b0;
  endtask

  // Deselected cycle with output enable low
  task automatic idl(int i, logic [3:0] eo, logic [35:0] ed);
    row(i, 8'hD7, 4'hF, 15'h0000, 36'h0, 1'b0, eo, ed);
  endtask

  task automatic run_tab(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      cmd   <= t_cmd[i];
      h_dq  <= t_dq[i];
      h_drv <= t_w[i];
      oe_n  <= t_w[i];
      slp   <= t_sl[i];
      #1;
      chk({32'h0, dq_oe_n}, {32'h0, t_eo[i]});
      chk(dq_o & lm(t_eo[i]), t_ed[i]);
      chk({35'h0, clash}, 36'h0);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_burst_wr();
    row(0, 8'h55, 4'hF, a0, pt(9'h001), 1'b1, 4'hF, 36'h0);
    row(1, 8'h59, 4'hF, a0, pt(9'h002), 1'b1, 4'hF, 36'h0);
    row(2, 8'h5D, 4'hF, a0, pt(9'h003), 1'b1, 4'hF, 36'h0);
    row(3, 8'h59, 4'hF, a0, pt(9'h004), 1'b1, 4'hF, 36'h0);
    row(4, 8'h59, 4'hF, a0, pt(9'h005), 1'b1, 4'hF, 36'h0);
    idl(5, 4'h0, pt(9'h005));
    idl(6, 4'hF, 36'h0);
    run_tab(7);
  endtask

  task automatic s_burst_rd();
    row(0, 8'h48, 4'h0, 15'h0012, 36'h0, 1'b0, 4'hF, 36'h0);
    row(1, 8'h5A, 4'hF, a0, 36'h0, 1'b0, 4'hF, 36'h0);
    row(2, 8'h5E, 4'hF, a0, 36'h0, 1'b0, 4'h0, pt(9'h004));
    row(3, 8'h5A, 4'hF, a0, 36'h0, 1'b0, 4'h0, pt(9'h005));
    idl(4, 4'h0, pt(9'h005));
    idl(5, 4'h0, pt(9'h001));
    idl(6, 4'hF, 36'h0);
    idl(7, 4'hF, 36'h0);
    run_tab(8);
  endtask

  task automatic s_ileave();
    @(posedge clk_sys_i);
    bo_sel <= 1'b1;
    row(0, 8'h48, 4'h0, a1, 36'h0, 1'b0, 4'hF, 36'h0);
    row(1, 8'h5A, 4'hF, a0, 36'h0, 1'b0, 4'hF, 36'h0);
    row(2, 8'hCA, 4'hF, a0, 36'h0, 1'b0, 4'h0, pt(9'h003));
    row(3, 8'h5A, 4'hF, a0, 36'h0, 1'b0, 4'h0, pt(9'h001));
    idl(4, 4'h0, pt(9'h005));
    idl(5, 4'h0, pt(9'h004));
    idl(6, 4'hF, 36'h0);
    idl(7, 4'hF, 36'h0);
    run_tab(8);
  endtask

  task automatic s_lane();
    row(0, 8'h56, 4'hE, a0, 36'h5_5555_55FF, 1'b1, 4'hF, 36'h0);
    row(1, 8'h48, 4'h0, a0, 36'h0, 1'b0, 4'hE, 36'h1FF);
    row(2, 8'h57, 4'h0, a1, 36'h0, 1'b0, 4'hF, 36'h0);
    idl(3, 4'h0, pt(9'h001) | 36'h1FF);
    idl(4, 4'h0, pt(9'h003));
    idl(5, 4'hF, 36'h0);
    idl(6, 4'hF, 36'h0);
    run_tab(7);
  endtask

  task automatic s_desel();
    row(0, 8'h15, 4'hF, a0, pt(9'h009), 1'b1, 4'hF, 36'h0);
    row(1, 8'h6F, 4'h0, a0, 36'h0, 1'b0, 4'hF, 36'h0);
    row(2, 8'hD5, 4'hF, a0, pt(9'h009), 1'b1, 4'hF, 36'h0);
    row(3, 8'h48, 4'h0, a0, 36'h0, 1'b0, 4'hF, 36'h0);
    idl(4, 4'hF, 36'h0);
    idl(5, 4'h0, pt(9'h001) | 36'h1FF);
    idl(6, 4'hF, 36'h0);
    idl(7, 4'hF, 36'h0);
    run_tab(8);
  endtask

  task automatic s_sleep();
    row(0, 8'h48, 4'h0, a1, 36'h0, 1'b0, 4'hF, 36'h0);
    idl(1, 4'hF, 36'h0);
    idl(2, 4'hF, 36'h0);
    idl(3, 4'hF, 36'h0);
    t_sl[2] = 1'b1;
    t_sl[3] = 1'b1;
    row(4, 8'h55, 4'hF, a1, pt(9'h007), 1'b1, 4'hF, 36'h0);
    row(5, 8'h55, 4'hF, a1, pt(9'h007), 1'b1, 4'hF, 36'h0);
    idl(6, 4'hF, 36'h0);
    row(7, 8'h48, 4'h0, a1, 36'h0, 1'b0, 4'hF, 36'h0);
    idl(8, 4'hF, 36'h0);
    idl(9, 4'h0, pt(9'h003));
    idl(10, 4'hF, 36'h0);
    idl(11, 4'hF, 36'h0);
    run_tab(12);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    bad_count   = 0;
    check_count = 0;
    srst_i      = 1'b1;
    cmd         = sbs_cmd_t'({8'hD7, 4'hF, 15'h0000});
    bo_sel      = 1'b0;
    slp         = 1'b0;
    oe_n        = 1'b0;
    h_drv       = 1'b0;
    h_dq        = 36'h0;
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    chk(dq_o, 36'h0);
    chk({32'h0, dq_oe_n}, {32'h0, 4'hF});
    s_burst_wr();
    s_burst_rd();
    s_ileave();
    s_lane();
    s_desel();
    s_sleep();
    print_verdict();
  end

  // Cuts a hang short
  initial begin
    #50000;
    bad_count++;
    $display("timeout at %0t", $time);
    print_verdict();
  end

endmodule
